// File: rtl/vbi_slicer_regs.svh
// Purpose: register indices, reset values, field positions for the slicer config block
// Assumes: byte address of a register is four times its index
// Notes: definitions only
//
// Summary of operation
// [RULE1] kana packing on at 0: first six bits form the first byte packet
// [RULE2] biphase decode of VPS lines at 0, raw sliced bits at 1
// [RULE3] run-in margin scale: 00 half, 01 unity, 10 double, 11 quadruple; resets 01
// [RULE4] edge realign enable, reset 1: resync on every data edge
// [RULE5] adaptive threshold at 0 averages run-in; at 1 fixed per mode
// [RULE6] 12-bit lower limit from low byte and high nibble, reset zero, mode-gated
// [RULE7] 12-bit upper limit from low nibble 1111 and high byte FF, mode-gated
// [RULE8] custom types one to three get data ids 1001, 1010, 1011
// [RULE9] clear bits 0..3 clear caption, guide 1x, guide 2x, widescreen FIFOs
// [RULE10] hamming enabled only when type field matches line type; zero disables
// [RULE11] hamming compares only the four low framing code bits
// [RULE12] status bit 7 shows parity fault of the byte
// [RULE13] status bit 6 shows full, bit 5 shows data available
// [RULE14] caption status bit 4: 0 odd-field caption, 1 even-field extended data
// [RULE15] status bits 1:0 count byte position in field, wrapping after four
// [RULE16] reading a data byte advances that FIFO's read pointer
// [RULE17] widescreen status parity bit always reads 0
// [RULE18] with filtering on keep only addresses within limits inclusive
// [RULE19] while a clear bit is held the FIFO stays empty, flags cleared
`ifndef VBI_SLICER_REGS_SVH
`define VBI_SLICER_REGS_SVH

`define IDX_MISC_CFG 12'h43C
`define IDX_TTX_LOW 12'h43D
`define IDX_TTX_MID 12'h43E
`define IDX_TTX_HIGH 12'h43F
`define IDX_ID_1_2 12'h440
`define IDX_ID_3 12'h441
`define IDX_FIFO_CLEAR 12'h442
`define IDX_HAMMING 12'h443
`define IDX_STAT_BASE 12'h444
`define IDX_IRQ_STATUS 12'h460
`define IDX_IRQ_CLEAR 12'h461
`define IDX_IRQ_ENABLE 12'h462

`define RST_MISC_CFG 8'h06
`define RST_TTX_LOW 8'h00
`define RST_TTX_MID 8'hF0
`define RST_TTX_HIGH 8'hFF
`define RST_ID_1_2 8'hA9
`define RST_ID_3 8'h0B
`define RST_FIFO_CLEAR 8'h00
`define RST_HAMMING 8'h00
`define MASK_MISC_CFG 8'h3F
`define MASK_LOW_NIBBLE 8'h0F

`define MISC_KANA_BIT 5
`define MISC_BIPHASE_BIT 4
`define MISC_MARGIN_LSB 2
`define MISC_REALIGN_BIT 1
`define MISC_ADAPT_BIT 0
`define STAT_PARITY_BIT 7
`define STAT_FULL_BIT 6
`define STAT_AVAIL_BIT 5
`define STAT_FIELD_BIT 4

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: rtl/vbi_slicer_pkg.sv
// Purpose: shared types of the slicer config block
// Assumes: nothing
// Notes: constants live in vbi_slicer_regs.svh
package vbi_slicer_pkg;
    // slicer-side settings driven out of the register bank
    typedef struct packed {
        logic kana_pack_disable;
        logic biphase_decode_disable;
        logic [1:0] runin_margin_scale;
        logic edge_realign_enable;
        logic adaptive_threshold_disable;
        logic [11:0] lower_limit;
        logic [11:0] upper_limit;
    } slicer_cfg_t;

    // one sliced payload byte from the slicer
    typedef struct packed {
        logic valid;
        logic field_start;
        logic parity_fault;
        logic xds_field;
        logic [7:0] data;
    } payload_in_t;

    // what a FIFO entry keeps beside the byte
    typedef struct packed {
        logic parity_fault;
        logic xds_field;
        logic [1:0] byte_num;
        logic [7:0] data;
    } payload_entry_t;
endpackage : vbi_slicer_pkg

// File: rtl/payload_fifo.sv
// Purpose: small payload FIFO with a level clear
// Assumes: pops on an empty FIFO and pushes on a full one are dropped
// Notes: clear wins over push and pop
`timescale 1ns/1ns
module payload_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clear,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic full,
    output logic not_empty,
    output logic overflow
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
    logic [AW:0] count_ff, nxt_count;
    logic do_push, do_pop;

    assign full = (count_ff == (AW+1)'(DEPTH)); // RULE13
    assign not_empty = (count_ff != '0); // RULE13
    assign head = mem[rd_ptr_ff];
    assign overflow = push && full && !clear;

    // pointer and count update; a held clear keeps it empty
    always_comb begin
        do_push = push && !full && !clear;
        do_pop = pop && not_empty && !clear;
        nxt_wr_ptr = do_push ? wr_ptr_ff + AW'(1) : wr_ptr_ff;
        nxt_rd_ptr = do_pop ? rd_ptr_ff + AW'(1) : rd_ptr_ff; // RULE16
        nxt_count = count_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
        if (clear) begin // RULE19
            nxt_wr_ptr = '0;
            nxt_rd_ptr = '0;
            nxt_count = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
        end
    end

    // storage has no reset, contents are only seen through count
    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem[wr_ptr_ff] <= push_data;
        end
    end
endmodule : payload_fifo

// File: rtl/vbi_slicer_cfg.sv
// Purpose: slicer configuration bank, teletext filter, hamming select, payload FIFOs
// Assumes: all slicer-side inputs synchronous to ref_clk
// Notes: registers reached over AXI4-Lite, one 8-bit register per word
`timescale 1ns/1ns
`include "vbi_slicer_regs.svh"
module vbi_slicer_cfg #(
    parameter int FIFO_DEPTH = 16,
    parameter int DEFAULT_MARGIN = 8
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [15:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire vbi_slicer_pkg::payload_in_t [3:0] payload_in,
    input wire logic ttx_valid,
    input wire logic [11:0] ttx_addr,
    input wire logic teletext_filter_mode_flag,
    input wire logic [3:0] line_data_type,
    input wire logic [7:0] frame_code,
    input wire logic [1:0] custom_type_sel,
    output vbi_slicer_pkg::slicer_cfg_t slicer_cfg,
    output logic [7:0] runin_margin,
    output logic ttx_judged,
    output logic ttx_keep,
    output logic hamming_enable,
    output logic [3:0] hamming_pattern,
    output logic [3:0] data_id,
    output logic irq
);
    localparam int EW = $bits(vbi_slicer_pkg::payload_entry_t);

    // bus state
    logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold, bvalid_ff, nxt_bvalid;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready, arready_ff, nxt_arready;
    logic rvalid_ff, nxt_rvalid;
    logic [11:0] widx_ff, nxt_widx;
    logic [7:0] wbyte_ff, nxt_wbyte;
    logic wlane_ff, nxt_wlane;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic wr_fire, ar_fire, wr_hit;
    logic [11:0] ridx;

    // register bank
    logic [7:0] misc_ff, nxt_misc, lo_ff, nxt_lo, mid_ff, nxt_mid, hi_ff, nxt_hi;
    logic [7:0] id12_ff, nxt_id12, id3_ff, nxt_id3, clr_ff, nxt_clr, ham_ff, nxt_ham;
    logic [7:0] irq_st_ff, nxt_irq_st, irq_en_ff, nxt_irq_en, irq_clr, irq_ev;
    logic irq_ff, nxt_irq;

    // slicer-side outputs
    logic [7:0] margin_ff, nxt_margin;
    logic judged_ff, nxt_judged, keep_ff, nxt_keep, ham_en_ff, nxt_ham_en;
    logic [3:0] ham_pat_ff, nxt_ham_pat, data_id_ff, nxt_data_id;

    // payload path
    logic [1:0] num_ff [4];
    logic [1:0] nxt_num [4];
    logic [3:0] pop, full, avail, ovf;
    logic [EW-1:0] head [4];
    logic [7:0] stat_byte [4];

    assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign ar_fire = s_axi_arvalid && arready_ff;
    assign ridx = s_axi_araddr[13:2];

    // write channel: address and data taken in either order
    always_comb begin
        nxt_aw_hold = aw_hold_ff;
        nxt_w_hold = w_hold_ff;
        nxt_bvalid = bvalid_ff;
        nxt_widx = widx_ff;
        nxt_wbyte = wbyte_ff;
        nxt_wlane = wlane_ff;
        nxt_bresp = bresp_ff;
        if (s_axi_awvalid && awready_ff) begin
            nxt_aw_hold = 1'b1;
            nxt_widx = s_axi_awaddr[13:2];
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_w_hold = 1'b1;
            nxt_wbyte = s_axi_wdata[7:0];
            nxt_wlane = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        nxt_awready = !nxt_aw_hold && !nxt_bvalid;
        nxt_wready = !nxt_w_hold && !nxt_bvalid;
    end

    // writable register decode; reserved bits forced to zero
    always_comb begin
        nxt_misc = misc_ff;
        nxt_lo = lo_ff;
        nxt_mid = mid_ff;
        nxt_hi = hi_ff;
        nxt_id12 = id12_ff;
        nxt_id3 = id3_ff;
        nxt_clr = clr_ff;
        nxt_ham = ham_ff;
        nxt_irq_en = irq_en_ff;
        irq_clr = 8'h00;
        wr_hit = 1'b1;
        case (widx_ff)
            `IDX_MISC_CFG: nxt_misc = wbyte_ff & `MASK_MISC_CFG;
            `IDX_TTX_LOW: nxt_lo = wbyte_ff; // RULE6
            `IDX_TTX_MID: nxt_mid = wbyte_ff; // RULE7
            `IDX_TTX_HIGH: nxt_hi = wbyte_ff;
            `IDX_ID_1_2: nxt_id12 = wbyte_ff;
            `IDX_ID_3: nxt_id3 = wbyte_ff & `MASK_LOW_NIBBLE;
            `IDX_FIFO_CLEAR: nxt_clr = wbyte_ff & `MASK_LOW_NIBBLE; // RULE9
            `IDX_HAMMING: nxt_ham = wbyte_ff & `MASK_LOW_NIBBLE;
            `IDX_IRQ_CLEAR: irq_clr = wbyte_ff;
            `IDX_IRQ_ENABLE: nxt_irq_en = wbyte_ff;
            `IDX_IRQ_STATUS: wr_hit = 1'b1;
            default: wr_hit = (widx_ff >= `IDX_STAT_BASE) && (widx_ff < `IDX_STAT_BASE + 12'h008);
        endcase
        // lane 0 holds the register; a write without it changes nothing
        if (!wr_fire || !wlane_ff) begin
            nxt_misc = misc_ff;
            nxt_lo = lo_ff;
            nxt_mid = mid_ff;
            nxt_hi = hi_ff;
            nxt_id12 = id12_ff;
            nxt_id3 = id3_ff;
            nxt_clr = clr_ff;
            nxt_ham = ham_ff;
            nxt_irq_en = irq_en_ff;
            irq_clr = 8'h00;
        end
    end

    // sticky events: byte stored [3:0], byte lost on full [7:4]; set beats clear
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            irq_ev[i] = payload_in[i].valid && !full[i] && !clr_ff[i];
            irq_ev[i+4] = ovf[i];
        end
        nxt_irq_st = (irq_st_ff & ~irq_clr) | irq_ev;
        nxt_irq = |(nxt_irq_st & nxt_irq_en);
    end

    // status byte per FIFO from the entry at the head
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            stat_byte[i] = 8'h00;
            stat_byte[i][`STAT_FULL_BIT] = full[i]; // RULE13
            stat_byte[i][`STAT_AVAIL_BIT] = avail[i]; // RULE13
            if (avail[i]) begin
                stat_byte[i][`STAT_PARITY_BIT] = head[i][EW-1]; // RULE12
                stat_byte[i][`STAT_FIELD_BIT] = head[i][EW-2]; // RULE14
                stat_byte[i][1:0] = head[i][9:8]; // RULE15
            end
        end
        stat_byte[3][`STAT_PARITY_BIT] = 1'b0; // RULE17
    end

    // read channel: answer one cycle after the address is taken
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        pop = 4'h0;
        if (ar_fire) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = `RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            case (ridx)
                `IDX_MISC_CFG: nxt_rdata[7:0] = misc_ff;
                `IDX_TTX_LOW: nxt_rdata[7:0] = lo_ff;
                `IDX_TTX_MID: nxt_rdata[7:0] = mid_ff;
                `IDX_TTX_HIGH: nxt_rdata[7:0] = hi_ff;
                `IDX_ID_1_2: nxt_rdata[7:0] = id12_ff;
                `IDX_ID_3: nxt_rdata[7:0] = id3_ff;
                `IDX_FIFO_CLEAR: nxt_rdata[7:0] = clr_ff;
                `IDX_HAMMING: nxt_rdata[7:0] = ham_ff;
                `IDX_IRQ_STATUS: nxt_rdata[7:0] = irq_st_ff;
                `IDX_IRQ_CLEAR: nxt_rdata[7:0] = 8'h00;
                `IDX_IRQ_ENABLE: nxt_rdata[7:0] = irq_en_ff;
                default: nxt_rresp = `RESP_SLVERR;
            endcase
            for (int i = 0; i < 4; i++) begin
                if (ridx == `IDX_STAT_BASE + 12'(2 * i)) begin
                    nxt_rdata[7:0] = stat_byte[i];
                    nxt_rresp = `RESP_OKAY;
                end
                if (ridx == `IDX_STAT_BASE + 12'(2 * i + 1)) begin
                    nxt_rdata[7:0] = avail[i] ? head[i][7:0] : 8'h00;
                    nxt_rresp = `RESP_OKAY;
                    pop[i] = 1'b1; // RULE16
                end
            end
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        nxt_arready = !nxt_rvalid;
    end

    // slicer-side decisions, registered toward the slicer
    always_comb begin
        case (misc_ff[`MISC_MARGIN_LSB +: 2]) // RULE3
            2'h0: nxt_margin = 8'(DEFAULT_MARGIN / 2);
            2'h1: nxt_margin = 8'(DEFAULT_MARGIN);
            2'h2: nxt_margin = 8'(DEFAULT_MARGIN * 2);
            default: nxt_margin = 8'(DEFAULT_MARGIN * 4);
        endcase
        nxt_judged = ttx_valid;
        // limits only gate packets when the line asks for filtering
        nxt_keep = ttx_valid && (!teletext_filter_mode_flag ||
            (ttx_addr >= slicer_cfg.lower_limit && ttx_addr <= slicer_cfg.upper_limit)); // RULE18
        nxt_ham_en = (ham_ff[3:0] != 4'h0) && (ham_ff[3:0] == line_data_type); // RULE10
        nxt_ham_pat = frame_code[3:0]; // RULE11
        case (custom_type_sel) // RULE8
            2'h1: nxt_data_id = id12_ff[3:0];
            2'h2: nxt_data_id = id12_ff[7:4];
            2'h3: nxt_data_id = id3_ff[3:0];
            default: nxt_data_id = 4'h0;
        endcase
    end

    // byte position within the field, restarted at each field
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            nxt_num[i] = num_ff[i];
            if (payload_in[i].field_start) begin
                nxt_num[i] = 2'h0;
            end
            if (payload_in[i].valid) begin
                nxt_num[i] = (payload_in[i].field_start ? 2'h0 : num_ff[i]) + 2'h1; // RULE15
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            widx_ff <= 12'h000;
            wbyte_ff <= 8'h00;
            wlane_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
            rresp_ff <= `RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
            misc_ff <= `RST_MISC_CFG; // RULE3
            lo_ff <= `RST_TTX_LOW;
            mid_ff <= `RST_TTX_MID;
            hi_ff <= `RST_TTX_HIGH;
            id12_ff <= `RST_ID_1_2;
            id3_ff <= `RST_ID_3;
            clr_ff <= `RST_FIFO_CLEAR;
            ham_ff <= `RST_HAMMING;
            irq_st_ff <= 8'h00;
            irq_en_ff <= 8'h00;
            irq_ff <= 1'b0;
            margin_ff <= 8'h00;
            judged_ff <= 1'b0;
            keep_ff <= 1'b0;
            ham_en_ff <= 1'b0;
            ham_pat_ff <= 4'h0;
            data_id_ff <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                num_ff[i] <= 2'h0;
            end
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            bvalid_ff <= nxt_bvalid;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            widx_ff <= nxt_widx;
            wbyte_ff <= nxt_wbyte;
            wlane_ff <= nxt_wlane;
            bresp_ff <= nxt_bresp;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
            misc_ff <= nxt_misc;
            lo_ff <= nxt_lo;
            mid_ff <= nxt_mid;
            hi_ff <= nxt_hi;
            id12_ff <= nxt_id12;
            id3_ff <= nxt_id3;
            clr_ff <= nxt_clr;
            ham_ff <= nxt_ham;
            irq_st_ff <= nxt_irq_st;
            irq_en_ff <= nxt_irq_en;
            irq_ff <= nxt_irq;
            margin_ff <= nxt_margin;
            judged_ff <= nxt_judged;
            keep_ff <= nxt_keep;
            ham_en_ff <= nxt_ham_en;
            ham_pat_ff <= nxt_ham_pat;
            data_id_ff <= nxt_data_id;
            for (int i = 0; i < 4; i++) begin
                num_ff[i] <= nxt_num[i];
            end
        end
    end

    // one FIFO per service: caption, guide 1x, guide 2x, widescreen
    for (genvar g = 0; g < 4; g++) begin : g_fifo
        vbi_slicer_pkg::payload_entry_t entry;
        assign entry.parity_fault = payload_in[g].parity_fault; // RULE12
        assign entry.xds_field = payload_in[g].xds_field; // RULE14
        assign entry.byte_num = payload_in[g].field_start ? 2'h0 : num_ff[g];
        assign entry.data = payload_in[g].data;
        payload_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) u_fifo (
            .ref_clk(ref_clk),
            .srst(srst),
            .clear(clr_ff[g]), // RULE9
            .push(payload_in[g].valid),
            .push_data(entry),
            .pop(pop[g]),
            .head(head[g]),
            .full(full[g]),
            .not_empty(avail[g]),
            .overflow(ovf[g])
        );
    end

    // outputs straight from registers
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign slicer_cfg.kana_pack_disable = misc_ff[`MISC_KANA_BIT]; // RULE1
    assign slicer_cfg.biphase_decode_disable = misc_ff[`MISC_BIPHASE_BIT]; // RULE2
    assign slicer_cfg.runin_margin_scale = misc_ff[`MISC_MARGIN_LSB +: 2];
    assign slicer_cfg.edge_realign_enable = misc_ff[`MISC_REALIGN_BIT]; // RULE4
    assign slicer_cfg.adaptive_threshold_disable = misc_ff[`MISC_ADAPT_BIT]; // RULE5
    assign slicer_cfg.lower_limit = {mid_ff[3:0], lo_ff}; // RULE6
    assign slicer_cfg.upper_limit = {hi_ff, mid_ff[7:4]}; // RULE7
    assign runin_margin = margin_ff;
    assign ttx_judged = judged_ff;
    assign ttx_keep = keep_ff;
    assign hamming_enable = ham_en_ff;
    assign hamming_pattern = ham_pat_ff;
    assign data_id = data_id_ff;
    assign irq = irq_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    AST_RESET_DEFAULTS: assert property ($fell(srst) |-> slicer_cfg.runin_margin_scale == 2'h1 // RULE3
        && slicer_cfg.edge_realign_enable && slicer_cfg.upper_limit == 12'hFFF)
        else $error("config defaults wrong after reset");
    AST_MARGIN_SCALE: assert property (slicer_cfg.runin_margin_scale == 2'h3 // RULE3
        && $stable(misc_ff) |=> runin_margin == 8'(DEFAULT_MARGIN * 4))
        else $error("run-in margin not quadrupled");
    AST_TTX_DROP: assert property (ttx_valid && teletext_filter_mode_flag // RULE18
        && (ttx_addr < slicer_cfg.lower_limit || ttx_addr > slicer_cfg.upper_limit)
        |=> ttx_judged && !ttx_keep)
        else $error("out of range packet kept");
    AST_TTX_NOFILTER: assert property (ttx_valid && !teletext_filter_mode_flag |=> ttx_keep) // RULE6
        else $error("packet dropped with filtering off");
    AST_HAM_ZERO: assert property (ham_ff[3:0] == 4'h0 |=> !hamming_enable) // RULE10
        else $error("hamming enabled with zero type");
    AST_HAM_LOW_BITS: assert property (line_data_type == ham_ff[3:0] && ham_ff[3:0] != 4'h0 // RULE11
        |=> hamming_enable && hamming_pattern == $past(frame_code[3:0]))
        else $error("hamming pattern not low framing bits");
    AST_DATA_ID_TWO: assert property (custom_type_sel == 2'h2 |=> data_id == $past(id12_ff[7:4])) // RULE8
        else $error("custom two data id wrong");
    AST_CLEAR_EMPTY: assert property (clr_ff[0] [*2] |-> stat_byte[0][6:5] == 2'h0) // RULE19
        else $error("caption FIFO not empty while cleared");
    AST_WSS_PARITY: assert property (stat_byte[3][`STAT_PARITY_BIT] == 1'b0) // RULE17
        else $error("widescreen parity bit set");
    AST_POP_ADVANCE: assert property (ar_fire && pop[0] && avail[0] && !clr_ff[0] // RULE16
        && !payload_in[0].valid |=> s_axi_rvalid ##0 $changed(g_fifo[0].u_fifo.rd_ptr_ff))
        else $error("data read did not advance pointer");
    AST_IRQ_LEVEL: assert property (irq == |(irq_st_ff & irq_en_ff))
        else $error("interrupt level does not match enabled status");

    COV_WRITE: cover property (wr_fire && widx_ff == `IDX_MISC_CFG);
    COV_CAPTION_READ: cover property (ar_fire && pop[0] && avail[0]);
    COV_TTX_DROP: cover property (ttx_judged && !ttx_keep);
    COV_IRQ: cover property ($rose(irq));
endmodule : vbi_slicer_cfg

// File: sim/test_vbi_slicer_cfg.sv
// Purpose: self-checking bench of the slicer config bank
// Assumes: FIFO depth cut to 4 so a full FIFO is reachable
// Notes: read answers are judged from a queue of expected words
`timescale 1ns/1ns
`include "vbi_slicer_regs.svh"
module test_vbi_slicer_cfg;
    logic ref_clk = 0, srst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, tv = 0, tf = 0;
    logic awr, wrd, bv, arr, rv, keep, jdg, hen, irq;
    logic [1:0] bresp, rresp, cs = 0;
    logic [15:0] aa = 0, ra = 0;
    logic [31:0] wd = 0, rdat, s = 64;
    logic [11:0] ta = 0;
    logic [3:0] lt = 0, hp, did;
    logic [7:0] fc = 0, marg, v;
    logic [7:0] d[5];
    logic [9:0] q[$];
    vbi_slicer_pkg::payload_in_t [3:0] pin = '0;
    vbi_slicer_pkg::slicer_cfg_t cfg;
    int error_cnt = 0, checks = 0, cyc = 0;
    logic [19:0] rt[8] = '{20'h43C06, 20'h43D00, 20'h43EF0, 20'h43FFF, 20'h440A9, 20'h4410B,
        20'h44300, 20'h44400};
    logic [11:0] at[5] = '{12'h133, 12'h134, 12'h2A8, 12'h2A9, 12'h133};

    vbi_slicer_cfg #(.FIFO_DEPTH(4)) i_dut (.ref_clk(ref_clk), .srst(srst), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_awaddr(aa), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ra),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .payload_in(pin), .ttx_valid(tv), .ttx_addr(ta), .teletext_filter_mode_flag(tf),
        .line_data_type(lt), .frame_code(fc), .custom_type_sel(cs), .slicer_cfg(cfg),
        .runin_margin(marg), .ttx_judged(jdg), .ttx_keep(keep), .hamming_enable(hen),
        .hamming_pattern(hp), .data_id(did), .irq(irq));

    initial forever #2 ref_clk = ~ref_clk;

    function logic [31:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : rnd

    task complete_run();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run

    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk

    // each channel released on its own handshake, response awaited after both
    task wr(input logic [11:0] i, input logic [7:0] x);
        aa <= {2'h0, i, 2'h0};
        wd <= {24'h0, x};
        awv <= 1;
        wv <= 1;
        do begin
            @(posedge ref_clk);
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
        end while ((awv && !awr) || (wv && !wrd));
        bre <= 1;
        do @(posedge ref_clk); while (!bv);
        chk("bresp", bresp, `RESP_OKAY);
        bre <= 0;
    endtask : wr

    // expectation queued here, judged by the watcher below
    task rd(input logic [11:0] i, input logic [9:0] e);
        ra <= {2'h0, i, 2'h0};
        arv <= 1;
        q.push_back(e);
        do @(posedge ref_clk); while (!arr);
        arv <= 0;
        rre <= 1;
        do @(posedge ref_clk); while (!rv);
        rre <= 0;
    endtask : rd

    // watcher and hang guard; upper read bits must stay zero
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run();
        end
        if (rv && rre) begin
            chk("rd", {rresp ^ rdat[31:30], rdat[29:0]}, {q[0][9:8], 22'h0, q[0][7:0]});
            void'(q.pop_front());
        end
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 0;
        @(posedge ref_clk);
        chk("cfg", cfg, {6'h06, 12'h000, 12'hFFF});
        foreach (rt[k]) rd(rt[k][19:8], {2'h0, rt[k][7:0]});
        rd(12'h500, 10'h200);
        for (int m = 0; m < 4; m++) begin
            void'(rnd());
            v = {2'h0, s[5:4], m[1:0], s[1:0]};
            wr(`IDX_MISC_CFG, v);
            @(posedge ref_clk);
            chk("cfg", cfg[29:24], v);
            chk("margin", marg, (16 << m) >> 2);
        end
        wr(`IDX_TTX_LOW, 8'h34);
        wr(`IDX_TTX_MID, 8'h81);
        wr(`IDX_TTX_HIGH, 8'h2A);
        wr(`IDX_HAMMING, 8'h05);
        // limit edges on both sides, then filtering off
        for (int k = 0; k < 5; k++) begin
            void'(rnd());
            @(posedge ref_clk);
            tv <= 1;
            ta <= at[k];
            tf <= k < 4;
            cs <= k[1:0];
            lt <= 4'(4 + k);
            fc <= s[7:0];
            @(posedge ref_clk);
            tv <= 0;
            @(posedge ref_clk);
            chk("keep", {jdg, keep}, 2 + (5'b10110 >> k & 1));
            chk("ham", {hen, hp}, {k == 1, s[3:0]});
            chk("id", did, 20'h0BA90 >> (4 * k) & 4'hF);
        end
        wr(`IDX_IRQ_ENABLE, 8'h01);
        // five pushes into a four-deep FIFO, the last one lost
        for (int k = 0; k < 5; k++) begin
            @(posedge ref_clk);
            void'(rnd());
            d[k] = s[7:0];
            pin[0] <= '{1'b1, k == 0, k == 1, 1'b1, s[7:0]};
        end
        @(posedge ref_clk);
        pin <= '0;
        repeat (2) @(posedge ref_clk);
        chk("irq", irq, 1);
        rd(`IDX_IRQ_STATUS, 10'h011);
        for (int k = 0; k < 4; k++) begin
            rd(`IDX_STAT_BASE, {2'h0, k == 1, k == 0, 4'hC, k[1:0]});
            rd(`IDX_STAT_BASE + 12'h001, {2'h0, d[k]});
        end
        rd(`IDX_STAT_BASE, 10'h000);
        wr(`IDX_IRQ_CLEAR, 8'hFF);
        @(posedge ref_clk);
        chk("irq", irq, 0);
        wr(`IDX_FIFO_CLEAR, 8'h01);
        @(posedge ref_clk);
        pin <= {4{12'hE5A}};
        @(posedge ref_clk);
        pin <= '0;
        rd(`IDX_STAT_BASE, 10'h000);
        rd(12'h44A, 10'h020);
        rd(12'h446, 10'h0A0);
        wr(`IDX_FIFO_CLEAR, 8'h00);
        complete_run();
    end
endmodule : test_vbi_slicer_cfg
